// [rtl/lmu_pkg.sv]
package lmu_pkg;
  // ****************************************
  // register indices and power-on values
  // ****************************************
  localparam int NREG = 6;
  localparam logic [7:0] REG_LDO_AB = 8'h00;
  localparam logic [7:0] REG_LDO_C = 8'h01;
  localparam logic [7:0] REG_BL_MAIN = 8'h02;
  localparam logic [7:0] REG_BL_SUB = 8'h03;
  localparam logic [7:0] REG_FLASH = 8'h04;
  localparam logic [7:0] REG_FADE = 8'h05;
  localparam logic [7:0] POR_LDO_AB = 8'h00;
  localparam logic [7:0] POR_LDO_C = 8'h00;
  localparam logic [7:0] POR_BL_MAIN = 8'h40;
  localparam logic [7:0] POR_BL_SUB = 8'h00;
  localparam logic [7:0] POR_FLASH = 8'hc3;
  localparam logic [7:0] POR_FADE = 8'h03;
  // ****************************************
  // field positions
  // ****************************************
  localparam int F_MEQS = 6;
  localparam int F_ON = 5;
  localparam int F_EN_LSB = 1;
  localparam int F_TIME_LSB = 2;
  localparam int F_HI_LSB = 4;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_KHZ = 200000;
  localparam int PUMP_KHZ = 1000;
  localparam int PUMP_HALF = CLK_KHZ / PUMP_KHZ / 2;
  localparam logic [9:0] FT_MS0 = 10'h064;
  localparam logic [9:0] FT_MS1 = 10'h0c8;
  localparam logic [9:0] FT_MS2 = 10'h190;
  localparam logic [9:0] FT_MS3 = 10'h320;
  // ****************************************
  // states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RX = 2'b01,
    ST_ACK = 2'b11,
    ST_IGN = 2'b10
  } link_state_t;
  typedef enum logic [1:0] {
    PM_1X = 2'b00,
    PM_1P5X = 2'b01,
    PM_2X = 2'b11
  } pump_mode_t;
endpackage : lmu_pkg

// [rtl/lmu_ctrl.sv]
// Overview of operation
// - device drives the data line only to acknowledge
// - address byte acknowledged only on own address match
// - register address byte follows and is acknowledged
// - data byte follows register address and is acknowledged
// - further data bytes acknowledged until stop
// - backlight current from 5-bit code, 0.5 to 31 mA
// - flash current from 4-bit code, 0 to 300 mA
// - seven backlight outputs and two flash outputs
// - flash on after rising lamp strobe and rising flash hold
// - flash held by hold input, cut at safety timeout
// - pump steps up when an active sink runs low
// - pump steps down from forward and input voltage compare
// - 150 mV hysteresis between pump modes
// - pump mode logic runs at 1 MHz
// - each regulator takes a 4-bit voltage code
// - each regulator enabled individually over serial writes
// - bytes shifted most significant bit first
// - acknowledge by holding data low for the ninth clock
// - regulator settings live only while select high; fall resets
`timescale 1ns/1ps
`default_nettype none
module lmu_ctrl #(
  parameter logic [6:0] DEV_ADDR = 7'h3c,
  parameter int unsigned MS_CYCLES = lmu_pkg::CLK_KHZ
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_link,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic lamp_group_strobe,
  input wire logic flash_hold_input,
  input wire logic regulator_select_strobe,
  input wire logic [6:0] bl_sink_low,
  input wire logic [1:0] fl_sink_low,
  input wire logic step_down_ok,
  output logic [4:0] bl_code_main,
  output logic [4:0] bl_code_sub,
  output logic [6:0] bl_en,
  output logic [3:0] fl_code,
  output logic [1:0] fl_en,
  output logic [3:0] ldo_code_a,
  output logic [3:0] ldo_code_b,
  output logic [3:0] ldo_code_c,
  output logic [2:0] ldo_en,
  output logic [1:0] pump_mode,
  output logic pump_clk
);
  // ****************************************
  // link side: sync, filter, byte engine
  // ****************************************
  logic [1:0] ls1_q, ls2_q, ls3_q, lf_q, lp_q, lf_d;
  lmu_pkg::link_state_t lst_q, lst_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wa_q, wa_d, wd_q, wd_d;
  logic [1:0] bidx_q, bidx_d;
  logic ack_q, ack_d, tg_q, tg_d;
  logic scl, sda, scl_rise, scl_fall, start, stop;

  assign scl = lf_q[1];
  assign sda = lf_q[0];
  assign scl_rise = scl & ~lp_q[1];
  assign scl_fall = ~scl & lp_q[1];
  assign start = scl & lp_q[1] & ~sda & lp_q[0];
  assign stop = scl & lp_q[1] & sda & ~lp_q[0];
  assign sda_o = 1'b0;
  assign sda_oe = ack_q;

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      // a level is taken only once two samples agree
      lf_d[i] = (ls2_q[i] == ls3_q[i]) ? ls3_q[i] : lf_q[i];
    end
    lst_d = lst_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    bidx_d = bidx_q;
    ptr_d = ptr_q;
    ack_d = ack_q;
    wa_d = wa_q;
    wd_d = wd_q;
    tg_d = tg_q;
    if (start)
    begin
      lst_d = lmu_pkg::ST_RX;
      cnt_d = 4'h0;
      bidx_d = 2'h0;
      ack_d = 1'b0;
    end
    else if (stop)
    begin
      lst_d = lmu_pkg::ST_IDLE;
      ack_d = 1'b0;
    end
    else
    begin
      case (lst_q)
        lmu_pkg::ST_RX:
        begin
          if (scl_rise && cnt_q != 4'h8)
          begin
            sh_d = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == 4'h8)
          begin
            lst_d = lmu_pkg::ST_ACK;
            ack_d = 1'b1;
            if (bidx_q == 2'h0 && (sh_q[7:1] != DEV_ADDR || sh_q[0]))
            begin
              lst_d = lmu_pkg::ST_IGN;
              ack_d = 1'b0;
            end
            else if (bidx_q == 2'h1)
            begin
              ptr_d = sh_q;
            end
            else if (bidx_q == 2'h2)
            begin
              wa_d = ptr_q;
              wd_d = sh_q;
              tg_d = ~tg_q;
              ptr_d = ptr_q + 8'h01;
            end
            if (bidx_q != 2'h2)
            begin
              bidx_d = bidx_q + 2'h1;
            end
          end
        end
        lmu_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            ack_d = 1'b0;
            lst_d = lmu_pkg::ST_RX;
            cnt_d = 4'h0;
          end
        end
        lmu_pkg::ST_IDLE, lmu_pkg::ST_IGN:
        begin
          lst_d = lst_q;
        end
        default:
        begin
          lst_d = lmu_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_link or negedge nrst)
  begin
    if (!nrst)
    begin
      ls1_q <= 2'h3;
      ls2_q <= 2'h3;
      ls3_q <= 2'h3;
      lf_q <= 2'h3;
      lp_q <= 2'h3;
      lst_q <= lmu_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      bidx_q <= 2'h0;
      ptr_q <= 8'h00;
      ack_q <= 1'b0;
      wa_q <= 8'h00;
      wd_q <= 8'h00;
      tg_q <= 1'b0;
    end
    else
    begin
      ls1_q <= {scl_i, sda_i};
      ls2_q <= ls1_q;
      ls3_q <= ls2_q;
      lf_q <= lf_d;
      lp_q <= lf_q;
      lst_q <= lst_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      bidx_q <= bidx_d;
      ptr_q <= ptr_d;
      ack_q <= ack_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      tg_q <= tg_d;
    end
  end

  // ****************************************
  // core side: sync, registers, flash, pump
  // ****************************************
  // the write word is held still between toggles, so it crosses unsynced
  logic [13:0] ss1_q, ss2_q, sp_q;
  logic [7:0] reg_q [lmu_pkg::NREG];
  logic [7:0] reg_d [lmu_pkg::NREG];
  logic lamp_arm_q, lamp_arm_d, fl_on_q, fl_on_d;
  logic [17:0] tick_q, tick_d;
  logic [9:0] fms_q, fms_d;
  logic [7:0] pc_q, pc_d;
  logic pclk_q, pclk_d;
  lmu_pkg::pump_mode_t pm_q, pm_d;
  logic [6:0] bl_en_q, bl_en_d;
  logic [2:0] ldo_en_q, ldo_en_d;
  logic lamp, hold, rsel, step_dn, wr, need_up, ms_tick, expired;
  logic [6:0] bl_low;
  logic [1:0] fl_low;

  assign {lamp, hold, rsel, bl_low, fl_low, step_dn} = ss2_q[13:1];
  assign wr = ss2_q[0] ^ sp_q[0];
  assign ms_tick = (tick_q == 18'(MS_CYCLES - 1));

  function automatic logic [9:0] limit_ms(input logic [1:0] code);
    case (code)
      2'h0: limit_ms = lmu_pkg::FT_MS0;
      2'h1: limit_ms = lmu_pkg::FT_MS1;
      2'h2: limit_ms = lmu_pkg::FT_MS2;
      default: limit_ms = lmu_pkg::FT_MS3;
    endcase
  endfunction : limit_ms

  assign expired = (fms_q >= limit_ms(reg_q[4][lmu_pkg::F_TIME_LSB +: 2]));
  assign need_up = |(bl_low & bl_en_q) | |(fl_low & fl_en);

  always_comb
  begin
    for (int i = 0; i < lmu_pkg::NREG; i++)
    begin
      reg_d[i] = reg_q[i];
    end
    if (wr && wa_q < 8'(lmu_pkg::NREG) && (wa_q > lmu_pkg::REG_LDO_C || rsel))
    begin
      reg_d[wa_q[2:0]] = wd_q;
    end
    if (!rsel && sp_q[11])
    begin
      reg_d[0] = lmu_pkg::POR_LDO_AB;
      reg_d[1] = lmu_pkg::POR_LDO_C;
    end
    // regulator outputs gated by the live select level
    ldo_en_d = rsel ? reg_q[1][lmu_pkg::F_EN_LSB +: 3] : 3'h0;
    bl_en_d = reg_q[2][lmu_pkg::F_MEQS] ? {7{reg_q[2][lmu_pkg::F_ON]}} :
      {{3{reg_q[3][lmu_pkg::F_ON]}}, {4{reg_q[2][lmu_pkg::F_ON]}}};
    lamp_arm_d = lamp & (lamp_arm_q | ~sp_q[13]);
    tick_d = ms_tick ? 18'h0_0000 : tick_q + 18'h0_0001;
    fms_d = (fl_on_q && ms_tick && !expired) ? fms_q + 10'h001 : fms_q;
    fl_on_d = fl_on_q;
    if (!hold || expired)
    begin
      fl_on_d = 1'b0;
    end
    else if (!sp_q[12] && lamp_arm_q)
    begin
      fl_on_d = 1'b1;
      fms_d = 10'h000;
    end
    pc_d = pc_q + 8'h01;
    pclk_d = pclk_q;
    pm_d = pm_q;
    if (pc_q == 8'(lmu_pkg::PUMP_HALF - 1))
    begin
      pc_d = 8'h00;
      pclk_d = ~pclk_q;
      if (!pclk_q)
      begin
        case (pm_q)
          lmu_pkg::PM_1X:
            pm_d = need_up ? lmu_pkg::PM_1P5X : lmu_pkg::PM_1X;
          lmu_pkg::PM_1P5X:
            pm_d = need_up ? lmu_pkg::PM_2X :
              (step_dn ? lmu_pkg::PM_1X : lmu_pkg::PM_1P5X);
          lmu_pkg::PM_2X:
            pm_d = (!need_up && step_dn) ? lmu_pkg::PM_1P5X : lmu_pkg::PM_2X;
          default:
            pm_d = lmu_pkg::PM_1X;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ss1_q <= 14'h0000;
      ss2_q <= 14'h0000;
      sp_q <= 14'h0000;
      reg_q[0] <= lmu_pkg::POR_LDO_AB;
      reg_q[1] <= lmu_pkg::POR_LDO_C;
      reg_q[2] <= lmu_pkg::POR_BL_MAIN;
      reg_q[3] <= lmu_pkg::POR_BL_SUB;
      reg_q[4] <= lmu_pkg::POR_FLASH;
      reg_q[5] <= lmu_pkg::POR_FADE;
      ldo_en_q <= 3'h0;
      bl_en_q <= 7'h00;
      lamp_arm_q <= 1'b0;
      fl_on_q <= 1'b0;
      tick_q <= 18'h0_0000;
      fms_q <= 10'h000;
      pc_q <= 8'h00;
      pclk_q <= 1'b0;
      pm_q <= lmu_pkg::PM_1X;
    end
    else
    begin
      ss1_q <= {lamp_group_strobe, flash_hold_input, regulator_select_strobe,
        bl_sink_low, fl_sink_low, step_down_ok, tg_q};
      ss2_q <= ss1_q;
      sp_q <= ss2_q;
      for (int i = 0; i < lmu_pkg::NREG; i++)
      begin
        reg_q[i] <= reg_d[i];
      end
      ldo_en_q <= ldo_en_d;
      bl_en_q <= bl_en_d;
      lamp_arm_q <= lamp_arm_d;
      fl_on_q <= fl_on_d;
      tick_q <= tick_d;
      fms_q <= fms_d;
      pc_q <= pc_d;
      pclk_q <= pclk_d;
      pm_q <= pm_d;
    end
  end

  assign bl_code_main = reg_q[2][4:0];
  assign bl_code_sub = reg_q[3][4:0];
  assign bl_en = bl_en_q;
  assign fl_code = reg_q[4][lmu_pkg::F_HI_LSB +: 4];
  assign fl_en = {2{fl_on_q}};
  assign ldo_code_a = reg_q[0][7:4];
  assign ldo_code_b = reg_q[0][3:0];
  assign ldo_code_c = reg_q[1][7:4];
  assign ldo_en = ldo_en_q;
  assign pump_mode = pm_q;
  assign pump_clk = pclk_q;

  // ****************************************
  // checks
  // ****************************************
  sequence s_flash_req;
    lamp_arm_q && hold && !sp_q[12] && !expired;
  endsequence

  chk_drive_ack: assert property (@(posedge clk_link) disable iff (!nrst)
    sda_oe |-> lst_q == lmu_pkg::ST_ACK) else $error("sda driven outside ack");
  chk_addr_match: assert property (@(posedge clk_link) disable iff (!nrst)
    $rose(ack_q) && $past(bidx_q) == 2'h0 |-> $past(sh_q) == {DEV_ADDR, 1'b0})
    else $error("ack on foreign or read address");
  chk_ack_release: assert property (@(posedge clk_link) disable iff (!nrst)
    ack_q && scl_fall && !start && !stop |=> !ack_q && cnt_q == 4'h0)
    else $error("ack not released");
  chk_msb_first: assert property (@(posedge clk_link) disable iff (!nrst)
    lst_q == lmu_pkg::ST_RX && scl_rise && cnt_q < 4'h8 && !start && !stop
    |=> sh_q == {$past(sh_q[6:0]), $past(sda)}) else $error("bad shift");
  chk_flash_on: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_flash_req |=> fl_on_q && fms_q == 10'h000) else $error("flash not on");
  chk_flash_off: assert property (@(posedge clk_sys) disable iff (!nrst)
    !hold || expired |=> !fl_on_q) else $error("flash not cut");
  chk_ldo_reset: assert property (@(posedge clk_sys) disable iff (!nrst)
    !rsel && sp_q[11] |=> reg_q[0] == lmu_pkg::POR_LDO_AB ##1 ldo_en == 3'h0)
    else $error("regulators not reset");
  chk_pump_up: assert property (@(posedge clk_sys) disable iff (!nrst)
    pc_q == 8'(lmu_pkg::PUMP_HALF - 1) && !pclk_q && need_up && pm_q == lmu_pkg::PM_1X
    |=> pm_q == lmu_pkg::PM_1P5X) else $error("pump did not step up");
  chk_pump_rate: assert property (@(posedge clk_sys) disable iff (!nrst)
    $changed(pclk_q) |-> $past(pc_q) == 8'(lmu_pkg::PUMP_HALF - 1))
    else $error("pump clock off rate");
endmodule : lmu_ctrl
`default_nettype wire

// [verif/i2c_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model #(
  parameter int Q = 8
) (
  input wire logic clk_link,
  input wire logic sda_in,
  output logic scl,
  output logic sda_drv
);
  logic ack_q;
  event ack_done;
  // ****************************************
  // bus phases, clock idles high
  // ****************************************
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    ack_q = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_link);
  endtask : tick
  task automatic start();
    sda_drv <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_drv <= 1'b0;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask : start
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sda_drv <= b[i];
      tick(Q);
      scl <= 1'b1;
      tick(2 * Q);
      scl <= 1'b0;
      tick(Q);
    end
    // released: pull-up shows high unless the target acknowledges
    sda_drv <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    ack_q = ~sda_in;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
    -> ack_done;
  endtask : send_byte
  task automatic stop();
    sda_drv <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_drv <= 1'b1;
    tick(2 * Q);
  endtask : stop
endmodule : i2c_master_model
`default_nettype wire

// [verif/i2c_write_lighting_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_write_lighting_control_tb;
  localparam logic [6:0] ADDR = 7'h3c;
  logic clk_sys;
  logic clk_link;
  logic nrst = 1'b0;
  logic lamp = 1'b0;
  logic hold = 1'b0;
  logic sel = 1'b0;
  logic [6:0] bl_low = 7'h00;
  logic [1:0] fl_low = 2'h0;
  logic down_ok = 1'b0;
  logic scl, m_sda, sda_line, sda_o, sda_oe, pump_clk;
  logic [4:0] bl_code_main, bl_code_sub, w;
  logic [6:0] bl_en;
  logic [3:0] fl_code, ldo_code_a, ldo_code_b, ldo_code_c, f;
  logic [2:0] ldo_en;
  logic [1:0] fl_en, pump_mode;
  logic [7:0] d0, d1;
  logic exp_q[$];
  int error_cnt = 0;
  int checks = 0;
  int seed = 32'h9645fe99;
  time t0;
  // the master drive and the acknowledge both pull the open-drain line low
  assign sda_line = m_sda & ~(sda_oe & ~sda_o);
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    clk_link = 1'b0;
    #1.3;
    forever #6 clk_link = ~clk_link;
  end
  lmu_ctrl #(.DEV_ADDR(ADDR), .MS_CYCLES(20)) lmu_ctrl_inst (.clk_sys(clk_sys), .nrst(nrst),
    .clk_link(clk_link), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .lamp_group_strobe(lamp), .flash_hold_input(hold), .regulator_select_strobe(sel),
    .bl_sink_low(bl_low), .fl_sink_low(fl_low), .step_down_ok(down_ok),
    .bl_code_main(bl_code_main), .bl_code_sub(bl_code_sub), .bl_en(bl_en), .fl_code(fl_code),
    .fl_en(fl_en), .ldo_code_a(ldo_code_a), .ldo_code_b(ldo_code_b), .ldo_code_c(ldo_code_c),
    .ldo_en(ldo_en), .pump_mode(pump_mode), .pump_clk(pump_clk));
  i2c_master_model i2c_master_model_inst (.clk_link(clk_link), .sda_in(sda_line), .scl(scl),
    .sda_drv(m_sda));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("counts checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic sys(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : sys
  task automatic frame(input logic [7:0] hdr, input logic ok, input logic [7:0] d[$]);
    i2c_master_model_inst.start();
    exp_q.push_back(ok);
    i2c_master_model_inst.send_byte(hdr);
    foreach (d[i])
    begin
      exp_q.push_back(ok);
      i2c_master_model_inst.send_byte(d[i]);
    end
    i2c_master_model_inst.stop();
    sys(10);
  endtask : frame
  task automatic next_mode(input logic [1:0] exp);
    logic [1:0] m;
    m = pump_mode;
    for (int i = 0; i < 400 && pump_mode === m; i++) @(posedge clk_sys);
    check(pump_mode, exp);
  endtask : next_mode
  // ****************************************
  // acknowledge watcher and hang limit
  // ****************************************
  initial
  forever
  begin
    @(i2c_master_model_inst.ack_done);
    check(i2c_master_model_inst.ack_q, exp_q.pop_front());
  end
  initial
  begin
    sys(80000);
    error_cnt++;
    results();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    sys(12);
    nrst <= 1'b1;
    sys(20);
    check({bl_code_main, fl_code, ldo_en, fl_en, pump_mode, sda_oe}, {5'h00, 4'hc, 8'h00});
    $display("test reset done");
    frame({ADDR ^ 7'h01, 1'b0}, 1'b0, '{8'h02, 8'h1f});
    frame({ADDR, 1'b1}, 1'b0, '{8'h02, 8'h1f});
    check(bl_code_main, 5'h00);
    $display("test refusal done");
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    frame({ADDR, 1'b0}, 1'b1, '{8'h00, d0, d1});
    check({ldo_code_a, ldo_en}, 7'h00);
    sel <= 1'b1;
    sys(10);
    frame({ADDR, 1'b0}, 1'b1, '{8'h00, d0, d1});
    check({ldo_code_a, ldo_code_b}, d0);
    check({ldo_code_c, ldo_en}, d1[7:1]);
    sel <= 1'b0;
    sys(10);
    check({ldo_code_a, ldo_code_c, ldo_en}, 11'h000);
    $display("test regulator done");
    w = 5'($random(seed));
    f = 4'($random(seed));
    frame({ADDR, 1'b0}, 1'b1, '{8'h02, {3'b011, w}, {3'b000, ~w}, {f, 4'h3}, 8'h03, 8'haa});
    check({bl_code_main, bl_code_sub}, {w, ~w});
    check({bl_en, fl_code}, {7'h7f, f});
    $display("test burst done");
    lamp <= 1'b1;
    sys(5);
    hold <= 1'b1;
    sys(10);
    check(fl_en, 2'b11);
    fl_low <= 2'b10;
    next_mode(2'b01);
    next_mode(2'b11);
    fl_low <= 2'b00;
    hold <= 1'b0;
    sys(10);
    check(fl_en, 2'b00);
    lamp <= 1'b0;
    sys(5);
    lamp <= 1'b1;
    sys(5);
    hold <= 1'b1;
    sys(1900);
    check(fl_en, 2'b11);
    sys(200);
    check(fl_en, 2'b00);
    hold <= 1'b0;
    lamp <= 1'b0;
    $display("test flash done");
    @(posedge pump_clk);
    t0 = $time;
    @(posedge pump_clk);
    check(32'(($time - t0) / 5), 32'd200);
    down_ok <= 1'b1;
    next_mode(2'b01);
    next_mode(2'b00);
    down_ok <= 1'b0;
    bl_low <= 7'h01 << ({$random(seed)} % 7);
    next_mode(2'b01);
    bl_low <= 7'h00;
    $display("test pump done");
    results();
  end
endmodule : i2c_write_lighting_control_tb
`default_nettype wire
